// ---- rtl/bsal_defines.vh ----
// Purpose: shared constants of the battery status and alarm logic
// Assumes: included by bare name from the rtl files
// Notes:   definitions only
`ifndef BSAL_DEFINES_VH
`define BSAL_DEFINES_VH

// ----------------------------------------------------------------------
// host command codes
// ----------------------------------------------------------------------
`define BSAL_CMD_CAP_ALARM      8'h01
`define BSAL_CMD_TIME_ALARM     8'h02
`define BSAL_CMD_VOLTAGE        8'h09
`define BSAL_CMD_ERR_MARGIN     8'h0C
`define BSAL_CMD_FULL_CAP       8'h10
`define BSAL_CMD_CHG_CURRENT    8'h14
`define BSAL_CMD_CHG_VOLTAGE    8'h15
`define BSAL_CMD_STATUS         8'h16
`define BSAL_CMD_RESET          8'h44
`define BSAL_RESET_KEY          16'h8009
`define BSAL_ERR_MARGIN_BLOCK   16'h0002
`define BSAL_ERR_MARGIN_RST     16'h0000

// ----------------------------------------------------------------------
// error codes, low nibble of the status word
// ----------------------------------------------------------------------
`define BSAL_ERR_OK             4'h0
`define BSAL_ERR_UNSUPPORTED    4'h3
`define BSAL_ERR_DENIED         4'h4

// ----------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------
`define BSAL_ST_OVER_CHARGE     15
`define BSAL_ST_STOP_CHARGING   14
`define BSAL_ST_RISE_RATE       13
`define BSAL_ST_OVER_TEMP       12
`define BSAL_ST_STOP_DRAINING   11
`define BSAL_ST_CAP_ALARM       9
`define BSAL_ST_TIME_ALARM      8
`define BSAL_ST_READY           7
`define BSAL_ST_DRAINING        6
`define BSAL_ST_FULL            5
`define BSAL_ST_EMPTY           4

// ----------------------------------------------------------------------
// eeprom image layout, low byte addresses
// ----------------------------------------------------------------------
`define BSAL_EE_DESIGN_CAP      5'h00
`define BSAL_EE_INIT_VOLTAGE    5'h02
`define BSAL_EE_FAST_CURRENT    5'h04
`define BSAL_EE_FAST_VOLTAGE    5'h06
`define BSAL_EE_CAP_ALARM       5'h08
`define BSAL_EE_PRIMARY_FLAGS   5'h0A
`define BSAL_EE_SECONDARY_FLAGS 5'h0B
`define BSAL_EE_CURRENT_GAIN    5'h0C
`define BSAL_EE_FIRST_EMPTY     5'h0E
`define BSAL_EE_FINAL_EMPTY     5'h10
`define BSAL_EE_LAST            5'h11
`define BSAL_WRITE_LOCK_BIT     4

// ----------------------------------------------------------------------
// thresholds and scaling
// ----------------------------------------------------------------------
`define BSAL_TEMP_CLEAR_DC      16'h01F4
`define BSAL_EMPTY_CLEAR_PCT    8'h14
`define BSAL_CURRENT_SHIFT      10

`endif

// ---- rtl/bsal_flag_cell.v ----
// Purpose: one status or alarm flag with set and clear conditions
// Assumes: eval is a one-cycle measurement update pulse
// Notes:   set beats clear; init_clr beats both
`timescale 1ns/1ps
`default_nettype none

module bsal_flag_cell (
    input  wire sys_clk,
    input  wire rst_n,
    input  wire init_clr,
    input  wire eval,
    input  wire set_cond,
    input  wire clr_cond,
    output reg  flag_ff
);

    reg nxt_flag;

    always @* begin
        nxt_flag = flag_ff;
        if (init_clr) begin
            nxt_flag = 1'b0;
        end else if (eval && set_cond) begin
            nxt_flag = 1'b1;
        end else if (eval && clr_cond) begin
            nxt_flag = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

endmodule // bsal_flag_cell

`default_nettype wire

// ---- rtl/bsal_status_core.v ----
// Purpose: battery status word, alarm flags and eeprom start-up image
// Assumes: host, eeprom reader and measurement inputs share sys_clk
// Notes:   the serial link framing lives outside; this block sees decoded
//          one-cycle read and write strobes with a command code
`timescale 1ns/1ps
`default_nettype none
`include "bsal_defines.vh"

module bsal_status_core #(
    parameter FULL_PCT = 96
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        host_rd,
    input  wire        host_wr,
    input  wire [7:0]  host_cmd,
    input  wire [15:0] host_wdata,
    output reg  [15:0] host_rdata_ff,
    output reg         host_ack_ff,
    output reg         ee_rd_req_ff,
    output reg  [4:0]  ee_addr_ff,
    input  wire        ee_rd_valid,
    input  wire [7:0]  ee_rd_data,
    output reg         image_ready_ff,
    input  wire        meas_update,
    input  wire        charging,
    input  wire        valid_charge,
    input  wire        over_current,
    input  wire        over_voltage,
    input  wire        temp_over_max,
    input  wire        rise_rate_over,
    input  wire [15:0] temp_deci_c,
    input  wire [15:0] voltage_mv,
    input  wire [15:0] remaining_charge,
    input  wire [7:0]  rel_charge_pct,
    input  wire [15:0] avg_time_to_empty,
    input  wire [15:0] raw_current,
    input  wire        learn_valid,
    input  wire [15:0] learned_capacity,
    output reg  [15:0] scaled_current_ff,
    output reg  [15:0] learned_full_capacity_ff,
    output reg  [15:0] charge_current_req_ff,
    output reg  [15:0] charge_voltage_req_ff,
    output reg  [15:0] first_empty_voltage_threshold_ff,
    output reg  [7:0]  secondary_flag_byte_ff,
    output reg         rm_load_ff,
    output reg  [15:0] rm_load_value_ff
);

    // ------------------------------------------------------------------
    // loader states
    // ------------------------------------------------------------------
    localparam [1:0] LD_IDLE = 2'b00;
    localparam [1:0] LD_REQ  = 2'b01;
    localparam [1:0] LD_WAIT = 2'b10;
    localparam [1:0] LD_DONE = 2'b11;

    reg [1:0]  ld_state_ff;
    reg [7:0]  low_byte_ff;
    reg [15:0] voltage_rep_ff;
    reg [15:0] fast_current_ff;
    reg [15:0] fast_voltage_ff;
    reg [15:0] cap_alarm_ff;
    reg [15:0] time_alarm_ff;
    reg [7:0]  primary_flag_byte_ff;
    reg [15:0] current_gain_ff;
    reg [15:0] final_empty_voltage_threshold_ff;
    reg [15:0] error_margin_register_ff;
    reg [3:0]  err_code_ff;
    reg        reload_ff;

    wire [15:0] word_in = {ee_rd_data, low_byte_ff};
    wire [15:0] neg_word = 16'h0000 - word_in;
    wire        write_lock_bit = primary_flag_byte_ff[`BSAL_WRITE_LOCK_BIT];
    wire        eval = meas_update & image_ready_ff;

    // ------------------------------------------------------------------
    // flag conditions
    // ------------------------------------------------------------------
    wire heat_cond  = temp_over_max | rise_rate_over;
    wire stop_cond  = over_current | over_voltage | heat_cond;
    wire [31:0] full_prod = learned_full_capacity_ff * FULL_PCT;
    wire [31:0] full_prod_div = full_prod / 32'd100;
    // saturate rather than wrap if the percentage is set above one hundred
    wire [15:0] full_target = (full_prod_div[31:16] != 16'h0000) ? 16'hFFFF :
                              full_prod_div[15:0];
    wire at_final  = voltage_mv <= final_empty_voltage_threshold_ff;
    wire valid_term = charging & heat_cond;

    wire f_over_charge;
    wire f_stop_charging;
    wire f_rise_rate;
    wire f_over_temp;
    wire f_stop_draining;
    wire f_cap_alarm;
    wire f_time_alarm;
    wire f_ready;
    wire f_draining;
    wire f_full;
    wire f_empty;

    // ------------------------------------------------------------------
    // status and alarm flags
    // ------------------------------------------------------------------
    bsal_flag_cell u_over_charge (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(valid_term),
        .clr_cond(~charging | ~heat_cond), .flag_ff(f_over_charge));
    bsal_flag_cell u_stop_charging (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(charging & stop_cond),
        .clr_cond(~charging | ~stop_cond), .flag_ff(f_stop_charging));
    bsal_flag_cell u_rise_rate (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(rise_rate_over),
        .clr_cond(~rise_rate_over), .flag_ff(f_rise_rate));
    bsal_flag_cell u_over_temp (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(temp_over_max),
        .clr_cond(temp_deci_c < `BSAL_TEMP_CLEAR_DC), .flag_ff(f_over_temp));
    bsal_flag_cell u_stop_draining (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(at_final),
        .clr_cond(~at_final), .flag_ff(f_stop_draining));
    bsal_flag_cell u_cap_alarm (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(remaining_charge < cap_alarm_ff),
        .clr_cond(cap_alarm_ff < remaining_charge), .flag_ff(f_cap_alarm));
    bsal_flag_cell u_time_alarm (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(~charging & (avg_time_to_empty < time_alarm_ff)),
        .clr_cond((time_alarm_ff < avg_time_to_empty) | valid_charge),
        .flag_ff(f_time_alarm));
    bsal_flag_cell u_ready (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(f_full | f_empty),
        .clr_cond(1'b0), .flag_ff(f_ready));
    bsal_flag_cell u_draining (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(~charging),
        .clr_cond(charging), .flag_ff(f_draining));
    bsal_flag_cell u_full (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(valid_term),
        .clr_cond(remaining_charge < full_target), .flag_ff(f_full));
    bsal_flag_cell u_empty (.sys_clk(sys_clk), .rst_n(rst_n), .init_clr(reload_ff),
        .eval(eval), .set_cond(at_final),
        .clr_cond(rel_charge_pct >= `BSAL_EMPTY_CLEAR_PCT), .flag_ff(f_empty));

    wire [15:0] status_word;
    assign status_word = {f_over_charge, f_stop_charging, f_rise_rate, f_over_temp,
                          f_stop_draining, 1'b0, f_cap_alarm, f_time_alarm,
                          f_ready, f_draining, f_full, f_empty, err_code_ff};

    // ------------------------------------------------------------------
    // host command decode
    // ------------------------------------------------------------------
    reg        rd_known;
    reg [15:0] rd_value;
    reg        wr_known;
    always @* begin
        rd_known = 1'b1;
        rd_value = 16'h0000;
        case (host_cmd)
            `BSAL_CMD_CAP_ALARM:   rd_value = cap_alarm_ff;
            `BSAL_CMD_TIME_ALARM:  rd_value = time_alarm_ff;
            `BSAL_CMD_VOLTAGE:     rd_value = voltage_rep_ff;
            `BSAL_CMD_ERR_MARGIN:  rd_value = error_margin_register_ff;
            `BSAL_CMD_FULL_CAP:    rd_value = learned_full_capacity_ff;
            `BSAL_CMD_CHG_CURRENT: rd_value = charge_current_req_ff;
            `BSAL_CMD_CHG_VOLTAGE: rd_value = charge_voltage_req_ff;
            `BSAL_CMD_STATUS:      rd_value = status_word;
            default:               rd_known = 1'b0;
        endcase
        wr_known = (host_cmd == `BSAL_CMD_CAP_ALARM) || (host_cmd == `BSAL_CMD_TIME_ALARM) ||
                   (host_cmd == `BSAL_CMD_ERR_MARGIN) || (host_cmd == `BSAL_CMD_RESET);
    end

    wire wr_ok = host_wr & ~write_lock_bit & wr_known & image_ready_ff;
    wire soft_reset = wr_ok && (host_cmd == `BSAL_CMD_RESET) &&
                      (host_wdata == `BSAL_RESET_KEY) &&
                      (error_margin_register_ff != `BSAL_ERR_MARGIN_BLOCK);

    // ------------------------------------------------------------------
    // host answers and error code
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_ack_ff   <= 1'b0;
            host_rdata_ff <= 16'h0000;
            err_code_ff   <= `BSAL_ERR_OK;
        end else begin
            host_ack_ff <= host_rd | host_wr;
            if (host_rd) begin
                host_rdata_ff <= rd_value;
            end
            // a new error in the same cycle wins over the read clear
            if (host_rd && !rd_known) begin
                err_code_ff <= `BSAL_ERR_UNSUPPORTED;
            end else if (host_wr && !wr_known) begin
                err_code_ff <= rd_known ? `BSAL_ERR_DENIED : `BSAL_ERR_UNSUPPORTED;
            end else if (host_wr && write_lock_bit) begin
                err_code_ff <= `BSAL_ERR_DENIED;
            end else if (host_rd || reload_ff) begin
                err_code_ff <= `BSAL_ERR_OK;
            end
        end
    end

    // ------------------------------------------------------------------
    // eeprom image loader
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_state_ff    <= LD_IDLE;
            ee_rd_req_ff   <= 1'b0;
            ee_addr_ff     <= `BSAL_EE_DESIGN_CAP;
            image_ready_ff <= 1'b0;
            reload_ff      <= 1'b1;
        end else begin
            reload_ff <= soft_reset;
            case (ld_state_ff)
                LD_IDLE: begin
                    image_ready_ff <= 1'b0;
                    ee_addr_ff     <= `BSAL_EE_DESIGN_CAP;
                    ld_state_ff    <= LD_REQ;
                end
                LD_REQ: begin
                    ee_rd_req_ff <= 1'b1;
                    ld_state_ff  <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (ee_rd_valid) begin
                        ee_rd_req_ff <= 1'b0;
                        if (ee_addr_ff == `BSAL_EE_LAST) begin
                            ld_state_ff <= LD_DONE;
                        end else begin
                            ee_addr_ff  <= ee_addr_ff + 5'h01;
                            ld_state_ff <= LD_REQ;
                        end
                    end
                end
                LD_DONE: begin
                    image_ready_ff <= ~soft_reset;
                    if (soft_reset) begin
                        ld_state_ff <= LD_IDLE;
                    end
                end
                default: ld_state_ff <= LD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // image fields and host writable settings
    // ------------------------------------------------------------------
    wire ee_take = (ld_state_ff == LD_WAIT) & ee_rd_valid;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_byte_ff                      <= 8'h00;
            learned_full_capacity_ff         <= 16'h0000;
            voltage_rep_ff                   <= 16'h0000;
            fast_current_ff                  <= 16'h0000;
            fast_voltage_ff                  <= 16'h0000;
            cap_alarm_ff                     <= 16'h0000;
            time_alarm_ff                    <= 16'h0000;
            primary_flag_byte_ff             <= 8'h00;
            secondary_flag_byte_ff           <= 8'h00;
            current_gain_ff                  <= 16'h0000;
            first_empty_voltage_threshold_ff <= 16'h0000;
            final_empty_voltage_threshold_ff <= 16'h0000;
            error_margin_register_ff         <= `BSAL_ERR_MARGIN_RST;
        end else begin
            if (ee_take) begin
                low_byte_ff <= ee_rd_data;
                case (ee_addr_ff)
                    `BSAL_EE_DESIGN_CAP + 5'h01:   learned_full_capacity_ff <= word_in;
                    `BSAL_EE_INIT_VOLTAGE + 5'h01: voltage_rep_ff <= word_in;
                    `BSAL_EE_FAST_CURRENT + 5'h01: fast_current_ff <= word_in;
                    `BSAL_EE_FAST_VOLTAGE + 5'h01: fast_voltage_ff <= word_in;
                    `BSAL_EE_CAP_ALARM + 5'h01:    cap_alarm_ff <= word_in;
                    `BSAL_EE_PRIMARY_FLAGS:        primary_flag_byte_ff <= ee_rd_data;
                    `BSAL_EE_SECONDARY_FLAGS:      secondary_flag_byte_ff <= ee_rd_data;
                    `BSAL_EE_CURRENT_GAIN + 5'h01: current_gain_ff <= word_in;
                    `BSAL_EE_FIRST_EMPTY + 5'h01:
                        first_empty_voltage_threshold_ff <= neg_word;
                    `BSAL_EE_FINAL_EMPTY + 5'h01:
                        final_empty_voltage_threshold_ff <= neg_word;
                    default: ;
                endcase
            end else begin
                if (learn_valid && image_ready_ff) begin
                    learned_full_capacity_ff <= learned_capacity;
                end
                if (eval) begin
                    voltage_rep_ff <= voltage_mv;
                end
                if (wr_ok && host_cmd == `BSAL_CMD_CAP_ALARM) begin
                    cap_alarm_ff <= host_wdata;
                end
                if (wr_ok && host_cmd == `BSAL_CMD_TIME_ALARM) begin
                    time_alarm_ff <= host_wdata;
                end
                if (wr_ok && host_cmd == `BSAL_CMD_ERR_MARGIN) begin
                    error_margin_register_ff <= host_wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // charger requests, current scaling, charge top-up
    // ------------------------------------------------------------------
    wire [31:0] cur_prod = raw_current * current_gain_ff;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_current_req_ff <= 16'h0000;
            charge_voltage_req_ff <= 16'h0000;
            scaled_current_ff     <= 16'h0000;
            rm_load_ff            <= 1'b0;
            rm_load_value_ff      <= 16'h0000;
        end else begin
            charge_current_req_ff <= f_stop_charging ? 16'h0000 : fast_current_ff;
            charge_voltage_req_ff <= fast_voltage_ff;
            scaled_current_ff     <= cur_prod[`BSAL_CURRENT_SHIFT +: 16];
            // charge is only ever raised, never lowered, at termination
            rm_load_ff <= eval & valid_term & (remaining_charge < full_target);
            if (eval && valid_term) begin
                rm_load_value_ff <= full_target;
            end
        end
    end

endmodule // bsal_status_core

`default_nettype wire

// ---- sim/bsal_asserts.sv ----
// Purpose: port assertions for the battery status core
// Assumes: one clock, reset async active low
// Notes:   bound into every core instance
`timescale 1ns/1ps
`default_nettype none
module bsal_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        host_rd,
    input wire logic        host_wr,
    input wire logic [7:0]  host_cmd,
    input wire logic [15:0] host_rdata_ff,
    input wire logic        host_ack_ff,
    input wire logic        ee_rd_req_ff,
    input wire logic [4:0]  ee_addr_ff,
    input wire logic        ee_rd_valid,
    input wire logic        image_ready_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic req = host_rd || host_wr;
    wire logic rd_st = host_rd && !host_wr && host_cmd == 8'h16;
    wire logic take = ee_rd_req_ff && ee_rd_valid;
    a_ack_follow: assert property (req |=> host_ack_ff) else $error("no ack");
    a_ack_quiet: assert property (!req |=> !host_ack_ff) else $error("stray ack");
    a_err_cleared: assert property (rd_st ##1 rd_st |=> host_rdata_ff[3:0] == 4'h0)
        else $error("error code kept");
    a_fetch_start: assert property ($rose(rst_n) |-> ##[1:3] (ee_rd_req_ff && ee_addr_ff == 5'h00))
        else $error("no fetch at 0");
    a_fetch_hold: assert property (ee_rd_req_ff && !ee_rd_valid |=> ee_rd_req_ff && $stable(ee_addr_ff))
        else $error("request dropped");
    a_fetch_step: assert property (take && ee_addr_ff != 5'h11 |=> !ee_rd_req_ff ##1
        (ee_rd_req_ff && ee_addr_ff == $past(ee_addr_ff, 2) + 5'h01)) else $error("bad step");
    a_image_done: assert property (take && ee_addr_ff == 5'h11 |-> ##[1:3] image_ready_ff)
        else $error("image not ready");
    a_quiet_ready: assert property (image_ready_ff |-> !ee_rd_req_ff) else $error("late fetch");
    cover property (take && ee_addr_ff == 5'h11);
    cover property (rd_st ##1 rd_st);
    cover property (host_wr && host_cmd == 8'h01);
endmodule // bsal_asserts
bind bsal_status_core bsal_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .host_rd(host_rd),
    .host_wr(host_wr), .host_cmd(host_cmd), .host_rdata_ff(host_rdata_ff),
    .host_ack_ff(host_ack_ff), .ee_rd_req_ff(ee_rd_req_ff), .ee_addr_ff(ee_addr_ff),
    .ee_rd_valid(ee_rd_valid), .image_ready_ff(image_ready_ff));
`default_nettype wire

// ---- sim/bsal_ee_model.sv ----
// Purpose: byte-wide serial eeprom behind the start-up loader
// Assumes: request held until valid is seen
// Notes:   odd addresses answer a cycle late; idle data toggles
`timescale 1ns/1ps
`default_nettype none
module bsal_ee_model (
    input  wire logic       sys_clk,
    input  wire logic       ee_rd_req_ff,
    input  wire logic [4:0] ee_addr_ff,
    output var  logic       ee_rd_valid,
    output var  logic [7:0] ee_rd_data
);
    logic [7:0] mem [0:17] = '{8'h08, 8'h07, 8'h30, 8'h2A, 8'h08, 8'h07, 8'hC4, 8'h3B, 8'hB4,
        8'h00, 8'h10, 8'h90, 8'hEE, 8'h02, 8'h16, 8'hDB, 8'hD8, 8'hDC};
    logic slow = 1'b0;
    initial {ee_rd_valid, ee_rd_data} = 9'h05A;
    always @(posedge sys_clk) begin
        ee_rd_valid <= 1'b0;
        ee_rd_data <= ~ee_rd_data;
        slow <= 1'b0;
        if (ee_rd_req_ff && !ee_rd_valid && ee_addr_ff[0] && !slow)
            slow <= 1'b1;
        else if (ee_rd_req_ff && !ee_rd_valid) begin
            ee_rd_valid <= 1'b1;
            ee_rd_data <= mem[ee_addr_ff];
        end
    end
endmodule // bsal_ee_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the battery status core
// Assumes: eeprom model holds a locked factory image
// Notes:   lock bit set, so the keyed reset stays out of reach
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, host_rd = 1'b0, host_wr = 1'b0, meas_update = 1'b0;
    logic [7:0] host_cmd = 8'h00;
    logic [5:0] lv = 6'h00;
    logic learn_valid = 1'b0;
    logic [15:0] raw_current = 16'h0000;
    logic [15:0] host_wdata = 16'h0000, temp_deci_c = 16'h0258, voltage_mv = 16'h2710;
    int err_count = 0, n_tests = 0;
    wire logic host_ack_ff, ee_rd_req_ff, ee_rd_valid, image_ready_ff, rm_load_ff;
    wire logic [4:0] ee_addr_ff;
    wire logic [7:0] ee_rd_data, secondary_flag_byte_ff;
    wire logic [15:0] host_rdata_ff, scaled_current_ff, learned_full_capacity_ff, rm_load_value_ff;
    wire logic [15:0] charge_current_req_ff, charge_voltage_req_ff;
    wire logic [15:0] first_empty_voltage_threshold_ff;
    bsal_status_core #(.FULL_PCT(96)) DUT (.sys_clk, .rst_n, .host_rd, .host_wr, .host_cmd,
        .host_wdata, .host_rdata_ff, .host_ack_ff, .ee_rd_req_ff, .ee_addr_ff, .ee_rd_valid,
        .ee_rd_data, .image_ready_ff, .meas_update, .charging(lv[5]), .valid_charge(lv[4]),
        .over_current(lv[3]), .over_voltage(lv[2]), .temp_over_max(lv[1]),
        .rise_rate_over(lv[0]), .temp_deci_c, .voltage_mv, .remaining_charge(voltage_mv),
        .rel_charge_pct(8'h32), .avg_time_to_empty(voltage_mv), .raw_current,
        .learn_valid, .learned_capacity(voltage_mv), .scaled_current_ff,
        .learned_full_capacity_ff, .charge_current_req_ff, .charge_voltage_req_ff,
        .first_empty_voltage_threshold_ff, .secondary_flag_byte_ff, .rm_load_ff, .rm_load_value_ff);
    bsal_ee_model u_ee (.sys_clk, .ee_rd_req_ff, .ee_addr_ff, .ee_rd_valid, .ee_rd_data);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e)
            $display("ERROR at %0t seen %h expected %h", $time, s, e);
        err_count += (s !== e);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // n back-to-back requests, then the last answer is compared under mask m
    task automatic host(input logic w, input logic [7:0] c, input logic [15:0] d, input int n,
                        input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        {host_rd, host_wr} <= {!w, w};
        host_cmd <= c;
        host_wdata <= d;
        repeat (n) @(posedge sys_clk);
        {host_rd, host_wr} <= 2'b00;
        @(negedge sys_clk);
        chk(host_rdata_ff & m, e);
        chk({15'h0000, host_ack_ff}, 16'h0001);
    endtask
    task automatic meas(input logic [5:0] v, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        lv <= v;
        meas_update <= 1'b1;
        @(posedge sys_clk);
        meas_update <= 1'b0;
        host(1'b0, 8'h16, 16'h0000, 1, m, e);
    endtask
    task automatic t_image();
        for (int i = 0; i < 400 && image_ready_ff !== 1'b1; i++) @(negedge sys_clk);
        chk({15'h0000, image_ready_ff}, 16'h0001);
        chk(learned_full_capacity_ff, 16'h0708);
        chk(charge_current_req_ff, 16'h0708);
        chk(charge_voltage_req_ff, 16'h3BC4);
        chk(first_empty_voltage_threshold_ff, 16'h24EA);
        chk({8'h00, secondary_flag_byte_ff}, 16'h0090);
        host(1'b0, 8'h09, 16'h0000, 1, 16'hFFFF, 16'h2A30);
        host(1'b0, 8'h01, 16'h0000, 1, 16'hFFFF, 16'h00B4);
        if (image_ready_ff !== 1'b1)
            conclude();
    endtask
    task automatic t_lock();
        host(1'b1, 8'h01, 16'h0010, 1, 16'h0000, 16'h0000);
        host(1'b0, 8'h16, 16'h0000, 1, 16'h000F, 16'h0004);
        host(1'b0, 8'h01, 16'h0000, 1, 16'hFFFF, 16'h00B4);
        host(1'b1, 8'h44, 16'h8009, 1, 16'h0000, 16'h0000);
        chk({15'h0000, image_ready_ff}, 16'h0001);
        host(1'b1, 8'h01, 16'h0010, 1, 16'h0000, 16'h0000);
        host(1'b0, 8'h16, 16'h0000, 2, 16'h000F, 16'h0000);
    endtask
    task automatic t_heat();
        meas(6'h00, 16'hF840, 16'h0040);
        meas(6'h2A, 16'hF840, 16'hD000);
        chk(charge_current_req_ff, 16'h0000);
        meas(6'h20, 16'hF000, 16'h1000);
        @(posedge sys_clk);
        temp_deci_c <= 16'h0190;
        voltage_mv <= 16'h2328;
        meas(6'h00, 16'hF840, 16'h0840);
    endtask
    // termination below the full target, then empty, capacity alarm and learning
    task automatic t_misc();
        @(posedge sys_clk);
        raw_current <= 16'h0400;
        voltage_mv <= 16'h0640;
        lv <= 6'h22;
        meas_update <= 1'b1;
        @(posedge sys_clk);
        meas_update <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0000, rm_load_ff}, 16'h0001);
        chk(rm_load_value_ff, 16'h06C0);
        chk(scaled_current_ff, 16'h02EE);
        host(1'b0, 8'h16, 16'h0000, 1, 16'h03B0, 16'h00B0);
        @(posedge sys_clk);
        voltage_mv <= 16'h0064;
        meas(6'h00, 16'h0BB0, 16'h0A90);
        @(posedge sys_clk);
        voltage_mv <= 16'h2710;
        meas(6'h00, 16'h0BB0, 16'h0080);
        @(posedge sys_clk);
        learn_valid <= 1'b1;
        @(posedge sys_clk);
        learn_valid <= 1'b0;
        host(1'b0, 8'h10, 16'h0000, 1, 16'hFFFF, 16'h2710);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_image();
        t_lock();
        t_heat();
        t_misc();
        conclude();
    end
endmodule // tb
`default_nettype wire
